// File: bmg_pkg.sv
// Package for the board memory decode and strap glue block.
// Assumes a single 10 MHz clock domain and a classic Wishbone register bus.
package bmg_pkg;

  // ------------------------------------------------------------
  // Register map (word addresses, byte address = 4 * index)
  // ------------------------------------------------------------
  localparam logic [3:0] BMG_IDX_PROG_VOLT = 4'h0;
  localparam logic [3:0] BMG_IDX_DOWN_RESET = 4'h1;
  localparam logic [3:0] BMG_IDX_STATUS = 4'h2;
  localparam logic [3:0] BMG_IDX_STRAP = 4'h3;
  localparam logic [3:0] BMG_IDX_DECODE = 4'h4;
  localparam int BMG_IDX_LSB = 2;
  localparam int BMG_IDX_W = 4;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int BMG_PD0_LSB = 8;
  localparam int BMG_PD1_LSB = 12;
  localparam int BMG_PD_W = 4;
  localparam logic [3:0] BMG_PD_EMPTY = 4'hf;
  localparam logic BMG_PROG_VOLT_RST = 1'b0;
  localparam logic BMG_DOWN_RESET_RST = 1'b0;

  // ------------------------------------------------------------
  // Encodings
  // ------------------------------------------------------------
  localparam logic [1:0] BMG_SIZE_1M = 2'h3;
  localparam logic [1:0] BMG_SIZE_2M = 2'h0;
  localparam logic [1:0] BMG_SIZE_4M = 2'h1;
  localparam logic [1:0] BMG_SIZE_8M = 2'h2;
  localparam logic [1:0] BMG_SPEED_60 = 2'h0;
  localparam logic [1:0] BMG_SPEED_70 = 2'h1;
  localparam logic [1:0] BMG_SPEED_80 = 2'h2;
  localparam logic [1:0] BMG_WIDTH_32 = 2'h0;
  localparam logic [1:0] BMG_WIDTH_16 = 2'h1;
  localparam logic [1:0] BMG_WIDTH_8 = 2'h2;
  localparam logic [1:0] BMG_BOOT_LINK = 2'h0;
  localparam logic [1:0] BMG_BOOT_ROM16 = 2'h2;
  localparam logic [1:0] BMG_BOOT_ROM8 = 2'h3;
  localparam logic [1:0] BMG_LINK_UNITY = 2'h0;
  localparam logic [1:0] BMG_LINK_10M = 2'h1;
  localparam logic [1:0] BMG_LINK_20M = 2'h2;
  localparam logic [2:0] BMG_CORE_UNITY = 3'h0;
  localparam logic [2:0] BMG_CORE_30M = 3'h3;
  localparam logic [2:0] BMG_CORE_40M = 3'h4;

  // SRAM capacity in KiB per width
  localparam logic [9:0] BMG_SRAM_KB_32 = 10'h200;
  localparam logic [9:0] BMG_SRAM_KB_16 = 10'h100;
  localparam logic [9:0] BMG_SRAM_KB_8 = 10'h080;
  // Module depth in Mwords
  localparam logic [3:0] BMG_DEPTH_1M = 4'h1;
  localparam logic [3:0] BMG_DEPTH_2M = 4'h2;
  localparam logic [3:0] BMG_DEPTH_4M = 4'h4;
  localparam logic [3:0] BMG_DEPTH_8M = 4'h8;
  // Speed in ns, zero for an unknown code
  localparam logic [7:0] BMG_NS_60 = 8'h3c;
  localparam logic [7:0] BMG_NS_70 = 8'h46;
  localparam logic [7:0] BMG_NS_80 = 8'h50;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic column_strobe_n;
    logic program_strobe_n;
    logic row_strobe_n;
    logic [3:0] byte_write_strobe_n;
  } bmg_strobe_s;

  typedef struct packed {
    logic chip_enable_n;
    logic output_enable_n;
    logic [3:0] byte_write_n;
  } bmg_sram_s;

  typedef struct packed {
    logic internal_mem_disable;
    logic [1:0] boot_source;
    logic link0_half_rate_select;
    logic [1:0] link_rate_select;
    logic [2:0] core_clock_select;
  } bmg_strap_s;

endpackage

// File: bmg_glue.sv
// Board memory decode, reset routing and strap glue.
// Assumes all pins synchronous to clk; registers on classic Wishbone.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - column strobe to chip enable, program to output enable
// - byte write strobes drive SRAM byte writes
// - SRAM width 8/16/32, default 32
// - capacity 256K at 16 bit, 128K at 8
// - size code 11=1M 00=2M 01=4M 10=8M
// - speed code 00=60 01=70 10=80 ns
// - reads return socket pins at 11:8, 15:12
// - presence field in every register read
// - decode uses socket 0 size code only
// - always assume the larger module
// - button, backplane, power-on drive power reset
// - port and mezzanine resets drive core reset
// - fitted link reads 0, absent reads 1
// - internal memory disable strap 0=use, 1=disable
// - boot strap 00 link, 10 ROM16, 11 ROM8
// - link rate codes; link0 half rate bit
// - core clock codes 000, 011 x6, 100 x8
// - error output to both development ports
// - empty socket presence bits read ones
// - downstream reset write drives both ports low
module bmg_glue #(
  parameter logic [1:0] SRAM_WIDTH_DEFAULT = bmg_pkg::BMG_WIDTH_32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // Processor strobes and SRAM bank 0
  input wire bmg_pkg::bmg_strobe_s mem_strobe_i,
  output bmg_pkg::bmg_sram_s sram_o,
  // Width jumper and module presence pins
  input wire logic [1:0] sram_width_jumper,
  input wire logic [3:0] socket0_presence,
  input wire logic socket0_fitted,
  input wire logic [3:0] socket1_presence,
  input wire logic socket1_fitted,
  // Decode results
  output logic [3:0] module_depth_mwords,
  output logic [7:0] module_speed_ns,
  output logic [7:0] slower_speed_ns,
  output logic [9:0] sram_capacity_kb,
  output logic sram_width_mismatch,
  // Reset sources and targets
  input wire logic panel_button_reset,
  input wire logic backplane_sys_reset,
  input wire logic power_on_detect,
  input wire logic panel_port_reset,
  input wire logic backplane_port_reset,
  input wire logic mezzanine_reset,
  output logic processor_power_reset_n,
  output logic processor_core_reset,
  output logic panel_down_reset_n,
  output logic backplane_down_reset_n,
  // Option strap block, high while link absent
  input wire bmg_pkg::bmg_strap_s option_strap_block,
  output bmg_pkg::bmg_strap_s strap_o,
  output logic unity_clock_mode,
  output logic link_rate_reserved,
  output logic core_clock_reserved,
  output logic [3:0] core_clock_multiplier,
  // Error forwarding
  input wire logic processor_error_output,
  output logic panel_error_n,
  output logic backplane_error_n
);
  import bmg_pkg::*;

  // ------------------------------------------------------------
  // SRAM strobe mapping
  // ------------------------------------------------------------
  // Row strobe is deliberately unused in this bank
  assign sram_o.chip_enable_n = mem_strobe_i.column_strobe_n;
  assign sram_o.output_enable_n = mem_strobe_i.program_strobe_n;
  assign sram_o.byte_write_n = mem_strobe_i.byte_write_strobe_n;

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic prog_volt_reg;
  logic prog_volt_next;
  logic down_reset_reg;
  logic down_reset_next;
  logic [1:0] sw_width_reg;
  logic [1:0] sw_width_next;
  logic ack_reg;
  logic ack_next;
  logic err_reg;
  logic err_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [BMG_IDX_W-1:0] idx;
  logic req;
  logic [BMG_PD_W-1:0] pd0;
  logic [BMG_PD_W-1:0] pd1;
  logic [31:0] pd_field;

  assign idx = wb_adr_i[BMG_IDX_LSB +: BMG_IDX_W];
  assign req = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;

  // Live pins, forced high when a socket is empty
  assign pd0 = socket0_fitted ? socket0_presence : BMG_PD_EMPTY;
  assign pd1 = socket1_fitted ? socket1_presence : BMG_PD_EMPTY;

  // Presence field common to every word read
  always_comb
  begin
    pd_field = '0;
    pd_field[BMG_PD0_LSB +: BMG_PD_W] = pd0;
    pd_field[BMG_PD1_LSB +: BMG_PD_W] = pd1;
  end

  // ------------------------------------------------------------
  // Wishbone next-state: one wait-free cycle, ack the cycle after
  // ------------------------------------------------------------
  always_comb
  begin
    prog_volt_next = prog_volt_reg;
    down_reset_next = down_reset_reg;
    sw_width_next = sw_width_reg;
    ack_next = 1'b0;
    err_next = 1'b0;
    rdata_next = rdata_reg;
    if (req)
    begin
      ack_next = 1'b1;
      rdata_next = pd_field;
      unique case (idx)
        BMG_IDX_PROG_VOLT:
        begin
          rdata_next[0] = prog_volt_reg;
          if (wb_we_i && wb_sel_i[0])
            prog_volt_next = wb_dat_i[0];
        end
        BMG_IDX_DOWN_RESET:
        begin
          rdata_next[0] = down_reset_reg;
          if (wb_we_i && wb_sel_i[0])
            down_reset_next = wb_dat_i[0];
        end
        BMG_IDX_STATUS:
        begin
          // Register bit is active high: 1 while the error is raised
          rdata_next[0] = processor_error_output;
          rdata_next[1] = sram_width_mismatch;
        end
        BMG_IDX_STRAP:
        begin
          // Straps sit above the presence field so bit 8 stays intact
          rdata_next[31:23] = strap_o;
        end
        BMG_IDX_DECODE:
        begin
          rdata_next[1:0] = sw_width_reg;
          rdata_next[7:4] = module_depth_mwords;
          rdata_next[23:16] = slower_speed_ns;
          if (wb_we_i && wb_sel_i[0])
            sw_width_next = wb_dat_i[1:0];
        end
        default:
        begin
          // Unmapped word answers with an error, no side effect
          ack_next = 1'b0;
          err_next = 1'b1;
          rdata_next = pd_field;
        end
      endcase
    end
  end

  // Register update
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      prog_volt_reg <= BMG_PROG_VOLT_RST;
      down_reset_reg <= BMG_DOWN_RESET_RST;
      sw_width_reg <= SRAM_WIDTH_DEFAULT;
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      rdata_reg <= '0;
    end
    else
    begin
      prog_volt_reg <= prog_volt_next;
      down_reset_reg <= down_reset_next;
      sw_width_reg <= sw_width_next;
      ack_reg <= ack_next;
      err_reg <= err_next;
      rdata_reg <= rdata_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_err_o = err_reg;
  assign wb_dat_o = rdata_reg;

  // ------------------------------------------------------------
  // Downstream reset and error forwarding
  // ------------------------------------------------------------
  // Register is active high, both port pins active low
  assign panel_down_reset_n = !down_reset_reg;
  assign backplane_down_reset_n = !down_reset_reg;
  assign panel_error_n = !processor_error_output;
  assign backplane_error_n = !processor_error_output;

  // ------------------------------------------------------------
  // Reset routing
  // ------------------------------------------------------------
  // Port resets never reach the power reset, only the core
  assign processor_power_reset_n =
    !(panel_button_reset || backplane_sys_reset || power_on_detect);
  assign processor_core_reset =
    panel_port_reset || backplane_port_reset || mezzanine_reset;

  // ------------------------------------------------------------
  // Module decode from socket 0, except slower speed from both
  // ------------------------------------------------------------
  // Small modules alias larger codes; map assumes the larger one
  always_comb
  begin
    unique case (socket0_presence[1:0])
      BMG_SIZE_1M: module_depth_mwords = BMG_DEPTH_1M;
      BMG_SIZE_2M: module_depth_mwords = BMG_DEPTH_2M;
      BMG_SIZE_4M: module_depth_mwords = BMG_DEPTH_4M;
      BMG_SIZE_8M: module_depth_mwords = BMG_DEPTH_8M;
    endcase
  end

  // Speed code of one socket, zero for the unused code
  function automatic logic [7:0] speed_ns(input logic [1:0] code);
    logic [7:0] ns;
    ns = '0;
    unique case (code)
      BMG_SPEED_60: ns = BMG_NS_60;
      BMG_SPEED_70: ns = BMG_NS_70;
      BMG_SPEED_80: ns = BMG_NS_80;
      default: ns = '0;
    endcase
    return ns;
  endfunction

  logic [7:0] ns0;
  logic [7:0] ns1;
  assign ns0 = socket0_fitted ? speed_ns(socket0_presence[3:2]) : '0;
  assign ns1 = socket1_fitted ? speed_ns(socket1_presence[3:2]) : '0;
  assign module_speed_ns = ns0;
  // Hint for timing software: slower of the fitted modules
  assign slower_speed_ns = (ns1 > ns0) ? ns1 : ns0;

  // ------------------------------------------------------------
  // SRAM width and capacity
  // ------------------------------------------------------------
  always_comb
  begin
    unique case (sram_width_jumper)
      BMG_WIDTH_16: sram_capacity_kb = BMG_SRAM_KB_16;
      BMG_WIDTH_8: sram_capacity_kb = BMG_SRAM_KB_8;
      default: sram_capacity_kb = BMG_SRAM_KB_32;
    endcase
  end
  // Flags disagreement between jumper and software setting
  assign sram_width_mismatch = (sram_width_jumper != sw_width_reg);

  // ------------------------------------------------------------
  // Option straps
  // ------------------------------------------------------------
  // Pins pass straight through: fitted link 0, absent 1
  assign strap_o = option_strap_block;
  assign unity_clock_mode =
    (option_strap_block.core_clock_select == BMG_CORE_UNITY);
  assign link_rate_reserved =
    (option_strap_block.link_rate_select == 2'h3);
  always_comb
  begin
    core_clock_reserved = 1'b0;
    unique case (option_strap_block.core_clock_select)
      BMG_CORE_UNITY: core_clock_multiplier = 4'h1;
      BMG_CORE_30M: core_clock_multiplier = 4'h6;
      BMG_CORE_40M: core_clock_multiplier = 4'h8;
      default:
      begin
        core_clock_multiplier = 4'h0;
        core_clock_reserved = 1'b1;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_ack_one_cycle;
    @(posedge clk) disable iff (reset)
      (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && idx <= BMG_IDX_DECODE)
        |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_one_cycle: assert property (p_ack_one_cycle) else $error("ack timing wrong");

  property p_pd_read;
    @(posedge clk) disable iff (reset)
      (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && !wb_we_i)
        |=> wb_dat_o[15:8] == {$past(pd1), $past(pd0)};
  endproperty
  a_pd_read: assert property (p_pd_read) else $error("presence field wrong");

  property p_empty_ones;
    @(posedge clk) disable iff (reset)
      (req && !socket1_fitted) |=> wb_dat_o[15:12] == BMG_PD_EMPTY;
  endproperty
  a_empty_ones: assert property (p_empty_ones) else $error("empty socket not ones");

  property p_down_reset;
    @(posedge clk) disable iff (reset)
      (req && wb_we_i && wb_sel_i[0] && idx == BMG_IDX_DOWN_RESET && wb_dat_i[0])
        |=> !panel_down_reset_n && !backplane_down_reset_n;
  endproperty
  a_down_reset: assert property (p_down_reset) else $error("down reset not driven");

  property p_power_reset;
    @(posedge clk) disable iff (reset)
      (panel_port_reset || mezzanine_reset) && !power_on_detect &&
        !panel_button_reset && !backplane_sys_reset
        |-> processor_power_reset_n && processor_core_reset;
  endproperty
  a_power_reset: assert property (p_power_reset) else $error("reset routed wrong");

  property p_sram_map;
    @(posedge clk) disable iff (reset)
      1'b1 |-> sram_o.chip_enable_n == mem_strobe_i.column_strobe_n &&
        sram_o.output_enable_n == mem_strobe_i.program_strobe_n &&
        sram_o.byte_write_n == mem_strobe_i.byte_write_strobe_n;
  endproperty
  a_sram_map: assert property (p_sram_map) else $error("sram strobe mapping wrong");

  property p_full_reset;
    @(posedge clk) disable iff (reset)
      (panel_button_reset || backplane_sys_reset || power_on_detect)
        |-> !processor_power_reset_n;
  endproperty
  a_full_reset: assert property (p_full_reset) else $error("full reset not routed");

  property p_strap_pass;
    @(posedge clk) disable iff (reset)
      1'b1 |-> strap_o == option_strap_block;
  endproperty
  a_strap_pass: assert property (p_strap_pass) else $error("strap pins altered");

  property p_depth;
    @(posedge clk) disable iff (reset)
      socket0_presence[1:0] == BMG_SIZE_8M |-> module_depth_mwords == BMG_DEPTH_8M;
  endproperty
  a_depth: assert property (p_depth) else $error("size decode wrong");

  property p_error_fwd;
    @(posedge clk) disable iff (reset)
      processor_error_output |-> !panel_error_n && !backplane_error_n;
  endproperty
  a_error_fwd: assert property (p_error_fwd) else $error("error not forwarded");

endmodule // bmg_glue

`default_nettype wire

// File: bmg_far_model.sv
// Far side model: processor memory strobes and two plugged modules.
// Assumes the bench sets wanted pin levels; pins follow one edge later.
`timescale 1ns/1ps
`default_nettype none
module bmg_far_model (
  // Clock
  input wire logic clk,
  // Wanted pin levels
  input wire logic [6:0] strobe_want,
  input wire logic [3:0] pd0_want,
  input wire logic [3:0] pd1_want,
  input wire logic fit0_want,
  input wire logic fit1_want,
  // Pins toward the glue
  output bmg_pkg::bmg_strobe_s mem_strobe_o,
  output logic [3:0] pd0_o,
  output logic [3:0] pd1_o,
  output logic fit0_o,
  output logic fit1_o
);
  import bmg_pkg::*;
  logic tog = 1'b0;
  // Pins change just after the edge; an empty socket floats, so its
  // pins wander instead of resting at ones the glue must supply
  always_ff @(posedge clk)
  begin
    tog <= ~tog;
    mem_strobe_o <= strobe_want;
    fit0_o <= fit0_want;
    fit1_o <= fit1_want;
    pd0_o <= fit0_want ? pd0_want : {tog, ~tog, tog, ~tog};
    pd1_o <= fit1_want ? pd1_want : {~tog, tog, ~tog, tog};
  end
endmodule // bmg_far_model
`default_nettype wire

// File: tb.sv
// Testbench for the board glue: Wishbone tasks and directed checks.
// Assumes the far side model drives strobes and module pins.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bmg_pkg::*;
  logic clk, reset, cyc, stb, we, ack, err, fit0, fit1, fit0_p, fit1_p;
  logic eo, mis, lrr, ccr, ucm, pwr_n, core_r, pdn_n, bdn_n, pe_n, be_n, e;
  logic [7:0] adr, spd, slo;
  logic [3:0] sel, pd0, pd1, pd0_p, pd1_p, dep, mul;
  logic [31:0] wd, dat, d;
  logic [6:0] sw;
  logic [1:0] jmp;
  logic [9:0] cap;
  logic [5:0] rs;
  bmg_strobe_s strb;
  bmg_sram_s sram;
  bmg_strap_s straps, strap_q;
  int n_fail = 0;
  int checks_done = 0;
  logic [3:0] dex [4] = '{4'h2, 4'h4, 4'h8, 4'h1};
  logic [7:0] nsx [4] = '{8'h3c, 8'h46, 8'h50, 8'h00};
  logic [9:0] capx [3] = '{10'h200, 10'h100, 10'h080};

  bmg_glue bmg_glue_inst (.clk(clk), .reset(reset), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wd), .wb_dat_o(dat), .wb_ack_o(ack), .wb_err_o(err),
    .mem_strobe_i(strb), .sram_o(sram), .sram_width_jumper(jmp),
    .socket0_presence(pd0_p), .socket0_fitted(fit0_p),
    .socket1_presence(pd1_p), .socket1_fitted(fit1_p),
    .module_depth_mwords(dep), .module_speed_ns(spd), .slower_speed_ns(slo),
    .sram_capacity_kb(cap), .sram_width_mismatch(mis),
    .panel_button_reset(rs[0]), .backplane_sys_reset(rs[1]),
    .power_on_detect(rs[2]), .panel_port_reset(rs[3]),
    .backplane_port_reset(rs[4]), .mezzanine_reset(rs[5]),
    .processor_power_reset_n(pwr_n), .processor_core_reset(core_r),
    .panel_down_reset_n(pdn_n), .backplane_down_reset_n(bdn_n),
    .option_strap_block(straps), .strap_o(strap_q), .unity_clock_mode(ucm),
    .link_rate_reserved(lrr), .core_clock_reserved(ccr),
    .core_clock_multiplier(mul), .processor_error_output(eo),
    .panel_error_n(pe_n), .backplane_error_n(be_n));

  bmg_far_model bmg_far_model_inst (.clk(clk), .strobe_want(sw),
    .pd0_want(pd0), .pd1_want(pd1), .fit0_want(fit0), .fit1_want(fit1),
    .mem_strobe_o(strb), .pd0_o(pd0_p), .pd1_o(pd1_p), .fit0_o(fit0_p),
    .fit1_o(fit1_p));

  // ----------------------------------------------------------
  // Clock and shared tasks
  // ----------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want)
    begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // Lets the model's one-edge delay pass, then samples mid-cycle
  task automatic pause;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask

  // Classic single cycle; waits bounded for ack or err
  task automatic wb(input logic w, input logic [3:0] idx, input logic [3:0] s,
    input logic [31:0] v, output logic [31:0] r, output logic er);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {2'h0, idx, 2'h0};
    sel <= s;
    wd <= v;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && err !== 1'b1 && n < 20);
    r = dat;
    er = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 20)
    begin
      n_fail++;
      complete_run();
    end
  endtask

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial
  begin
    reset = 1'b1;
    {cyc, stb, we, adr, sel, wd} = '0;
    {sw, pd0, pd1, fit0, fit1} = {7'h7f, 8'hff, 2'b11};
    {jmp, rs, eo} = '0;
    straps = '0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    wb(1'b0, BMG_IDX_PROG_VOLT, 4'hf, 0, d, e);
    check(d[0], 0);
    wb(1'b0, BMG_IDX_DECODE, 4'hf, 0, d, e);
    check(d[1:0], BMG_WIDTH_32);
    check({pdn_n, bdn_n}, 2'b11);
    // Strobes straight through; row strobe plays no part
    for (int k = 0; k < 128; k++)
    begin
      @(posedge clk);
      sw <= k[6:0];
      pause();
      check(sram, {k[6], k[5], k[3:0]});
    end
    // Presence field live in every mapped register
    @(posedge clk);
    {pd0, pd1} <= 8'h96;
    pause();
    for (int i = 0; i < 5; i++)
    begin
      wb(1'b0, i[3:0], 4'hf, 0, d, e);
      check(d[15:8], 8'h69);
    end
    @(posedge clk);
    {pd0, fit1} <= {4'h5, 1'b0};
    pause();
    wb(1'b0, BMG_IDX_STATUS, 4'hf, 0, d, e);
    check(d[15:8], 8'hf5);
    wb(1'b1, 4'h9, 4'hf, 1, d, e);
    check(e, 1);
    fit1 <= 1'b1;
    // Size decode from socket 0 only
    for (int c = 0; c < 4; c++)
    begin
      @(posedge clk);
      {pd0, pd1} <= {2'h0, c[1:0], 2'h0, ~c[1:0]};
      pause();
      check(dep, dex[c]);
      wb(1'b0, BMG_IDX_DECODE, 4'hf, 0, d, e);
      check(d[7:4], dex[c]);
    end
    // Speed codes and the slower of the two
    for (int a = 0; a < 4; a++)
      for (int b = 0; b < 3; b++)
      begin
        @(posedge clk);
        {pd0, pd1} <= {a[1:0], 2'h0, b[1:0], 2'h0};
        pause();
        check(spd, nsx[a]);
        check(slo, (nsx[a] > nsx[b]) ? nsx[a] : nsx[b]);
      end
    // Reset sources: three full, three core only
    for (int k = 0; k < 7; k++)
    begin
      @(posedge clk);
      rs <= (k < 6) ? 6'(1 << k) : 6'h0;
      pause();
      check({pwr_n, core_r}, (k < 3) ? 2'b00 : (k < 6) ? 2'b11 : 2'b10);
    end
    // Strap pins and their decodes
    for (int k = 0; k < 512; k++)
    begin
      @(posedge clk);
      straps <= k[8:0];
      pause();
      check(strap_q, k[8:0]);
      check(ucm, k[2:0] == 3'h0);
      check(ccr, !(k[2:0] inside {3'h0, 3'h3, 3'h4}));
      check(mul, (k[2:0] == 3'h0) ? 1 : (k[2:0] == 3'h3) ? 6 :
        (k[2:0] == 3'h4) ? 8 : 0);
      check(lrr, k[4:3] == 2'h3);
    end
    // Error output to both ports
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk);
      eo <= k[0];
      pause();
      check({pe_n, be_n}, {~k[0], ~k[0]});
      wb(1'b0, BMG_IDX_STATUS, 4'hf, 0, d, e);
      check(d[0], k[0]);
    end
    // Width jumper, capacity and agreement with software
    for (int j = 0; j < 3; j++)
    begin
      @(posedge clk);
      jmp <= j[1:0];
      pause();
      check(cap, capx[j]);
      check(mis, j != 0);
    end
    wb(1'b1, BMG_IDX_DECODE, 4'hf, 32'(BMG_WIDTH_8), d, e);
    wb(1'b0, BMG_IDX_STATUS, 4'hf, 0, d, e);
    check(d[1], 0);
    // Downstream reset, with a write lacking lane 0 ignored
    wb(1'b1, BMG_IDX_DOWN_RESET, 4'hf, 1, d, e);
    check({pdn_n, bdn_n}, 2'b00);
    wb(1'b1, BMG_IDX_DOWN_RESET, 4'he, 0, d, e);
    wb(1'b0, BMG_IDX_DOWN_RESET, 4'hf, 0, d, e);
    check({d[0], pdn_n, bdn_n}, 3'b100);
    wb(1'b1, BMG_IDX_DOWN_RESET, 4'hf, 0, d, e);
    check({pdn_n, bdn_n}, 2'b11);
    // Programming voltage bit, strap word and slower speed readback
    wb(1'b1, BMG_IDX_PROG_VOLT, 4'hf, 1, d, e);
    wb(1'b0, BMG_IDX_PROG_VOLT, 4'hf, 0, d, e);
    check(d[0], 1);
    wb(1'b0, BMG_IDX_STRAP, 4'hf, 0, d, e);
    check(d[31:23], straps);
    wb(1'b0, BMG_IDX_DECODE, 4'hf, 0, d, e);
    check(d[23:16], 8'h50);
    // Mid-run reset brings registers back to their defaults
    wb(1'b1, BMG_IDX_DOWN_RESET, 4'hf, 1, d, e);
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    wb(1'b0, BMG_IDX_PROG_VOLT, 4'hf, 0, d, e);
    check(d[0], 0);
    check({pdn_n, bdn_n}, 2'b11);
    wb(1'b0, BMG_IDX_DECODE, 4'hf, 0, d, e);
    check(d[1:0], BMG_WIDTH_32);
    complete_run();
  end
endmodule // tb
`default_nettype wire
